// ---- hw/eoc_pkg.sv ----
/*
  Package for the external oscillator control block: mode codes, drive level width,
  stability counts and edge timeout constants.
  Assumes a single 125 MHz system clock domain.
*/
package eoc_pkg;
  localparam int DRIVE_W = 3;
  localparam int MODE_W = 3;
  // mode codes on the mode input
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_CMOS = 3'h2;
  localparam logic [2:0] MODE_RC = 3'h4;
  localparam logic [2:0] MODE_CAP = 3'h5;
  localparam logic [2:0] MODE_XTAL = 3'h6;
  localparam logic [2:0] MODE_XTAL_DIV2 = 3'h7;
  localparam logic [2:0] DRIVE_RESET = 3'h0;
  localparam logic [2:0] MODE_RESET = 3'h0;
  // stability: consecutive oscillator edges before valid
  localparam int STABLE_EDGES = 64;
  localparam int STABLE_W = 7;
  // an oscillator edge must come within this many system cycles
  localparam int EDGE_TIMEOUT = 255;
  localparam int TIMEOUT_W = 8;
endpackage

// ---- hw/eoc_sync3.sv ----
/*
  Three-stage synchroniser with agreement filter for one pin level.
  Assumes the input is asynchronous to clk; output changes when stages two and three agree.
*/
`timescale 1ns/10ps
module eoc_sync3 (
  input wire logic clk,
  input wire logic reset,
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dout <= 1'b0;
    end else if (s2_q == s3_q) begin
      dout <= s3_q;
    end
  end
endmodule

// ---- hw/eoc_top.sv ----
/*
  External oscillator control: mode and drive level, pin configuration, valid detector,
  divide-by-two stage and a glitch-free system clock source switch.
  Assumes the oscillator signal arrives on osc_pin_b_in and is oversampled by clk.
*/
//
// Behaviour
// - Divide-by-two crystal mode halves the oscillator, giving exact 50% duty.
// - Three-bit drive level gives eight bias levels, 000 lowest to 111 highest.
// - Valid flag rises once the external oscillator has stabilised after enable.
// - RC and C modes leave pin A untouched; only pin B is used.
// - CMOS clock mode always reports the valid flag as zero.
// - Oscillator output serves as system clock source and peripheral clock.
// - Source change applies once a rising edge of each source has been seen.
`timescale 1ns/10ps
module eoc_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] ext_osc_mode,
  input wire logic [2:0] ext_osc_drive_level,
  input wire logic osc_pin_b_in,
  input wire logic sel_ext_source,
  input wire logic internal_osc,
  output logic ext_osc_valid_flag,
  output logic [2:0] drive_level_out,
  output logic osc_pin_a_analog,
  output logic osc_pin_b_analog,
  output logic osc_pin_b_digital_in,
  output logic osc_amp_enable,
  output logic ext_clock_out,
  output logic periph_clock_out,
  output logic system_clock,
  output logic ext_source_active
);
  logic osc_s;
  logic osc_prev_q;
  logic osc_rise;
  logic div2_q;
  logic ext_clk_d;
  logic [2:0] mode_q;
  logic [6:0] stable_cnt_q;
  logic [7:0] gap_cnt_q;
  logic mode_change;
  logic sel_q;
  logic int_prev_q;
  logic int_rise;
  logic wait_ext_q;
  logic wait_int_q;

  function automatic logic mode_is_xtal(input logic [2:0] m);
    mode_is_xtal = (m == eoc_pkg::MODE_XTAL) || (m == eoc_pkg::MODE_XTAL_DIV2);
  endfunction

  function automatic logic mode_is_rcc(input logic [2:0] m);
    mode_is_rcc = (m == eoc_pkg::MODE_RC) || (m == eoc_pkg::MODE_CAP);
  endfunction

  eoc_sync3 u_sync_osc (
    .clk(clk),
    .reset(reset),
    .din(osc_pin_b_in),
    .dout(osc_s)
  );

  assign osc_rise = osc_s && !osc_prev_q;
  assign int_rise = internal_osc && !int_prev_q;
  assign mode_change = (ext_osc_mode != mode_q);

  always_ff @(posedge clk) begin
    if (reset) begin
      osc_prev_q <= 1'b0;
      int_prev_q <= 1'b0;
      mode_q <= eoc_pkg::MODE_RESET;
    end else begin
      osc_prev_q <= osc_s;
      int_prev_q <= internal_osc;
      mode_q <= ext_osc_mode;
    end
  end

  // pin configuration per mode
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_pin_a_analog <= 1'b0;
      osc_pin_b_analog <= 1'b0;
      osc_pin_b_digital_in <= 1'b0;
      osc_amp_enable <= 1'b0;
      drive_level_out <= eoc_pkg::DRIVE_RESET;
    end else begin
      osc_pin_a_analog <= mode_is_xtal(ext_osc_mode);
      osc_pin_b_analog <= mode_is_xtal(ext_osc_mode) || mode_is_rcc(ext_osc_mode);
      osc_pin_b_digital_in <= (ext_osc_mode == eoc_pkg::MODE_CMOS);
      osc_amp_enable <= mode_is_xtal(ext_osc_mode) || mode_is_rcc(ext_osc_mode);
      drive_level_out <= ext_osc_drive_level;
    end
  end

  // valid detector: count edges, each within the timeout
  always_ff @(posedge clk) begin
    if (reset || mode_change || ext_osc_mode == eoc_pkg::MODE_OFF) begin
      stable_cnt_q <= 7'h00;
      gap_cnt_q <= 8'h00;
    end else if (osc_rise) begin
      gap_cnt_q <= 8'h00;
      if (stable_cnt_q != 7'(eoc_pkg::STABLE_EDGES)) begin
        stable_cnt_q <= stable_cnt_q + 7'h01;
      end
    end else if (gap_cnt_q == 8'(eoc_pkg::EDGE_TIMEOUT)) begin
      stable_cnt_q <= 7'h00;
    end else begin
      gap_cnt_q <= gap_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || mode_change) begin
      ext_osc_valid_flag <= 1'b0;
    end else if (ext_osc_mode == eoc_pkg::MODE_CMOS) begin
      ext_osc_valid_flag <= 1'b0;
    end else begin
      ext_osc_valid_flag <= (ext_osc_mode != eoc_pkg::MODE_OFF)
        && (stable_cnt_q == 7'(eoc_pkg::STABLE_EDGES));
    end
  end

  // divide-by-two toggles only on rising edges: equal high and low halves
  always_ff @(posedge clk) begin
    if (reset || ext_osc_mode != eoc_pkg::MODE_XTAL_DIV2) begin
      div2_q <= 1'b0;
    end else if (osc_rise) begin
      div2_q <= !div2_q;
    end
  end

  always_comb begin
    ext_clk_d = 1'b0;
    if (ext_osc_mode == eoc_pkg::MODE_XTAL_DIV2) begin
      ext_clk_d = div2_q;
    end else if (ext_osc_mode != eoc_pkg::MODE_OFF) begin
      ext_clk_d = osc_s;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ext_clock_out <= 1'b0;
      periph_clock_out <= 1'b0;
    end else begin
      ext_clock_out <= ext_clk_d;
      periph_clock_out <= ext_clk_d;
    end
  end

  // source switch: wait for a rising edge of each source before changing over
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_q <= 1'b0;
      wait_ext_q <= 1'b0;
      wait_int_q <= 1'b0;
    end else if (sel_ext_source != sel_q) begin
      if (wait_ext_q && wait_int_q) begin
        sel_q <= sel_ext_source;
        wait_ext_q <= 1'b0;
        wait_int_q <= 1'b0;
      end else begin
        wait_ext_q <= wait_ext_q || (ext_clk_d && !ext_clock_out);
        wait_int_q <= wait_int_q || int_rise;
      end
    end else begin
      wait_ext_q <= 1'b0;
      wait_int_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      system_clock <= 1'b0;
      ext_source_active <= 1'b0;
    end else begin
      system_clock <= sel_q ? ext_clk_d : internal_osc;
      ext_source_active <= sel_q;
    end
  end

  AST_CMOS_NO_VALID: assert property (@(posedge clk) disable iff (reset)
    ext_osc_mode == eoc_pkg::MODE_CMOS |=> !ext_osc_valid_flag)
    else $error("valid set in cmos mode");

  AST_CHANGE_CLEARS: assert property (@(posedge clk) disable iff (reset)
    mode_change |=> !ext_osc_valid_flag)
    else $error("valid not cleared on mode change");

  AST_PIN_A_RC: assert property (@(posedge clk) disable iff (reset)
    mode_is_rcc(ext_osc_mode) |=> !osc_pin_a_analog)
    else $error("pin a touched in rc mode");

  AST_XTAL_PINS: assert property (@(posedge clk) disable iff (reset)
    mode_is_xtal(ext_osc_mode) |=> osc_pin_a_analog && osc_pin_b_analog)
    else $error("crystal pins not analog");

  AST_VALID_NEEDS_COUNT: assert property (@(posedge clk) disable iff (reset)
    $rose(ext_osc_valid_flag) |-> $past(stable_cnt_q) == 7'(eoc_pkg::STABLE_EDGES))
    else $error("valid without stable count");

  AST_DIV2_HALF: assert property (@(posedge clk) disable iff (reset)
    ext_osc_mode == eoc_pkg::MODE_XTAL_DIV2 && $past(ext_osc_mode) == eoc_pkg::MODE_XTAL_DIV2
    && osc_rise |=> div2_q != $past(div2_q))
    else $error("divider missed an edge");

  AST_DRIVE_FOLLOW: assert property (@(posedge clk) disable iff (reset)
    ##1 drive_level_out == $past(ext_osc_drive_level))
    else $error("drive level not applied");

  AST_SWITCH_WAIT: assert property (@(posedge clk) disable iff (reset)
    $changed(sel_q) |-> $past(wait_ext_q) && $past(wait_int_q))
    else $error("source switched before both periods");
endmodule

// ---- tb/eoc_osc_model.sv ----
/*
  Oscillator source on pin B: a square wave while run is high.
  Assumes its edges fall on clk falling edges; the line stands low when stopped.
*/
`timescale 1ns/10ps
module eoc_osc_model #(parameter int HALF_NS = 80) (
  input wire logic run,
  output logic pin_b
);
  initial begin
    pin_b = 1'b0;
    forever begin
      #(HALF_NS);
      pin_b = run ? ~pin_b : 1'b0;
    end
  end
endmodule

// ---- tb/external_oscillator_control_test.sv ----
/*
  Self-checking bench for eoc_top: pin setup, valid detector, divide-by-two, source switch.
  Assumes eoc_osc_model drives pin B with a 160 ns period.
*/
`timescale 1ns/10ps
module external_oscillator_control_test;
  logic clk, reset, sel, run, pin_b, valid, pa, pb, pbd, amp, ext, per, sclk, act;
  logic iosc = 1'b0;
  logic [2:0] mode, drive, dlo;
  int bad_count, tests_run;
  eoc_top uut (.clk(clk), .reset(reset), .ext_osc_mode(mode), .ext_osc_drive_level(drive),
    .osc_pin_b_in(pin_b), .sel_ext_source(sel), .internal_osc(iosc),
    .ext_osc_valid_flag(valid), .drive_level_out(dlo), .osc_pin_a_analog(pa),
    .osc_pin_b_analog(pb), .osc_pin_b_digital_in(pbd), .osc_amp_enable(amp),
    .ext_clock_out(ext), .periph_clock_out(per), .system_clock(sclk),
    .ext_source_active(act));
  eoc_osc_model osc (.run(run), .pin_b(pin_b));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) iosc <= ~iosc;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic go(input logic [2:0] m, input int n);
    mode = m;
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_valid();
    for (int i = 0; i < 3000 && valid !== 1'b1; i++) @(negedge clk);
    chk(valid, 1'b1);
  endtask
  task automatic t_pins();
    logic [2:0] m [6] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [3:0] e [6] = '{4'h0, 4'h2, 4'h5, 4'h5, 4'hD, 4'hD};
    for (int i = 0; i < 6; i++) begin
      drive = m[i];
      go(m[i], 2);
      chk({pa, pb, pbd, amp}, e[i]);
      chk(dlo, m[i]);
    end
  endtask
  task automatic t_xtal();
    int n, h;
    n = 0;
    h = 0;
    drive = 3'h7;
    go(3'h6, 1);
    wait_valid();
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      n += int'(ext !== per);
      h += int'(ext === 1'b1);
    end
    chk(n, 0);
    chk(h, 20);
  endtask
  task automatic t_div2();
    int hi, lo;
    hi = 0;
    lo = 0;
    go(3'h7, 1);
    chk(valid, 1'b0);
    repeat (50) @(negedge clk);
    for (int i = 0; i < 100 && ext !== 1'b0; i++) @(negedge clk);
    for (int i = 0; i < 100 && ext !== 1'b1; i++) @(negedge clk);
    for (int i = 0; i < 100 && ext === 1'b1; i++) begin
      hi++;
      @(negedge clk);
    end
    for (int i = 0; i < 100 && ext === 1'b0; i++) begin
      lo++;
      @(negedge clk);
    end
    chk(hi, 20);
    chk(lo, 20);
  endtask
  task automatic t_cmos();
    int n;
    n = 0;
    go(3'h2, 1);
    for (int i = 0; i < 1500; i++) begin
      @(negedge clk);
      n += int'(valid !== 1'b0);
    end
    chk(n, 0);
  endtask
  task automatic t_switch();
    int n;
    n = 0;
    drive = 3'h2;
    go(3'h4, 1);
    wait_valid();
    sel = 1'b1;
    for (int i = 0; i < 60 && act !== 1'b1; i++) @(negedge clk);
    chk(act, 1'b1);
    // system clock must track the external clock once switched
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      n += int'(sclk !== ext);
    end
    chk(n, 0);
    sel = 1'b0;
    for (int i = 0; i < 60 && act !== 1'b0; i++) @(negedge clk);
    chk(act, 1'b0);
    go(3'h0, 1);
    chk(valid, 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {reset, sel, run, mode, drive, bad_count, tests_run} = '0;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    t_pins();
    run = 1'b1;
    t_xtal();
    t_div2();
    t_cmos();
    t_switch();
    tally_and_finish();
  end
endmodule
